//--- kds_scanner_regs.vh
// Register map, field positions and timing constants of the key/display scanner
`ifndef KDS_SCANNER_REGS_VH
`define KDS_SCANNER_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define KDS_ADDR_W 8
`define KDS_OFF_CTRL 8'h00
`define KDS_OFF_KEY 8'h04
`define KDS_OFF_STAT 8'h08
`define KDS_SEG_BASE_BIT 7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define KDS_CTRL_EN 0
`define KDS_CTRL_RST 1'b1
`define KDS_KEY_CODE_HI 5
`define KDS_KEY_SHIFT 8
`define KDS_KEY_CTRL 9
`define KDS_KEY_VALID 31
`define KDS_STAT_COL_HI 4
`define KDS_STAT_RUN 8
`define KDS_STAT_PRESS 9

// ----------------------------------------------------------------
// Matrix and display geometry
// ----------------------------------------------------------------
`define KDS_DIGITS 20
`define KDS_ROWS 3
`define KDS_SEGS 15
`define KDS_SEG_DECIMAL_POINT 14
`define KDS_COL_W 5
`define KDS_CODE_W 6
`define KDS_LAST_COL 5'h13

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define KDS_CLK_MHZ 100
`define KDS_US_PER_MS 1000
`define KDS_FIRST_DWELL_MS 10
`define KDS_DWELL_US 1000
`define KDS_CNT_W 20

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define KDS_RESP_OKAY 2'h0
`define KDS_RESP_SLVERR 2'h2

`endif

//--- kds_sync.v
// Three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/1ns
module kds_sync #(
	parameter WIDTH = 5,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;
integer i;

always @(posedge aclk) begin
	if (!aresetn) begin
		stage1 <= RESET_VAL;
		stage2 <= RESET_VAL;
		stage3 <= RESET_VAL;
		sync_out <= RESET_VAL;
	end else begin
		stage1 <= async_in;
		stage2 <= stage1;
		stage3 <= stage2;
		for (i = 0; i < WIDTH; i = i + 1) begin
			if (stage2[i] == stage3[i]) begin
				sync_out[i] <= stage3[i];
			end
		end
	end
end

endmodule // kds_sync

//--- kds_scanner.v
// Multiplexed display driver and key matrix scanner with AXI4-Lite registers
//
// Summary of operation
// - Digit selects 1-8, 9-16, 17-20 map to select bits 0-7, 8-15, 16-19.
// - Segments a-h on segment bits 0-7, the rest to point on bits 8-14.
// - Segment lines are active low: zero lights, one extinguishes.
// - Digit lines are active low: zero selects, one deselects.
// - Matrix is 20 columns by 3 rows, each node has its own code.
// - Three pulled-up row inputs are sensed; idle reads as one.
// - Position counter clears at scan start, counts released nodes.
// - Scan starts with first digit low for 10 ms, checking first column.
// - No key found: move to next digit leftward, rows top to bottom.
// - A zero row while a column is low identifies the pressed key.
// - Shift and control inputs are sampled and reported with each key.
// - Every digit refreshes at least 20 times per second, not too fast.
// - A key is re-examined after more than 10 ms, less than 50 ms.
// - A key still held from the last scan is not reported again.
// - Segment pattern changes together with its digit select; a segment write to the selected digit changes the pattern alone.
`timescale 1ns/1ns
`include "kds_scanner_regs.vh"
module kds_scanner #(
	parameter FIRST_DWELL_CYC =
		`KDS_FIRST_DWELL_MS * `KDS_US_PER_MS * `KDS_CLK_MHZ,
	parameter DWELL_CYC = `KDS_DWELL_US * `KDS_CLK_MHZ
) (
	input wire aclk,
	input wire aresetn,
	input wire [`KDS_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`KDS_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [`KDS_DIGITS-1:0] digit_select_n,
	output reg [`KDS_SEGS-1:0] segment_n,
	input wire [`KDS_ROWS-1:0] key_row_n,
	input wire shift_key_input_n,
	input wire control_key_input_n
);

localparam [`KDS_CNT_W-1:0] FIRST_END = FIRST_DWELL_CYC - 1;
localparam [`KDS_CNT_W-1:0] DWELL_END = DWELL_CYC - 1;
localparam ST_OFF = 1'b0;
localparam ST_RUN = 1'b1;
localparam [`KDS_COL_W-1:0] COL_ZERO = 5'h00;
localparam [`KDS_CODE_W-1:0] CODE_STEP = 6'h03;

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
wire [`KDS_ROWS+1:0] pins_sync;
wire [`KDS_ROWS-1:0] row_n;
wire shift_n;
wire ctrl_n;

kds_sync #(
	.WIDTH(`KDS_ROWS + 2),
	.RESET_VAL({(`KDS_ROWS + 2){1'b1}})
) u_sync (
	.aclk(aclk),
	.aresetn(aresetn),
	.async_in({control_key_input_n, shift_key_input_n, key_row_n}),
	.sync_out(pins_sync)
);

assign row_n = pins_sync[`KDS_ROWS-1:0];
assign shift_n = pins_sync[`KDS_ROWS];
assign ctrl_n = pins_sync[`KDS_ROWS+1];

// ----------------------------------------------------------------
// Registers and segment memory
// ----------------------------------------------------------------
reg scan_en;
reg [`KDS_SEGS-1:0] seg_mem [0:`KDS_DIGITS-1];
reg key_valid;
reg [`KDS_CODE_W-1:0] key_code;
reg key_shift;
reg key_ctrl;

// ----------------------------------------------------------------
// Scan state
// ----------------------------------------------------------------
reg state;
reg [`KDS_COL_W-1:0] col;
reg [`KDS_CNT_W-1:0] dwell_cnt;
reg [`KDS_CODE_W-1:0] pos_cnt;
reg found;
reg [`KDS_CODE_W-1:0] found_code;
reg prev_found;
reg [`KDS_CODE_W-1:0] prev_code;

wire dwell_done;
wire last_col;
wire [`KDS_CNT_W-1:0] dwell_end;
reg hit;
reg [`KDS_CODE_W-1:0] hit_code;
wire frame_found;
wire [`KDS_CODE_W-1:0] frame_code;
wire new_press;

// First column holds for the long dwell, the others for the short one
assign dwell_end = (col == COL_ZERO) ? FIRST_END : DWELL_END;
assign dwell_done = (state == ST_RUN) && (dwell_cnt == dwell_end);
assign last_col = (col == `KDS_LAST_COL);

// Rows examined top to bottom; a zero marks a closed contact
always @* begin
	hit = 1'b0;
	hit_code = pos_cnt;
	if (!row_n[0]) begin
		hit = 1'b1;
		hit_code = pos_cnt;
	end else if (!row_n[1]) begin
		hit = 1'b1;
		hit_code = pos_cnt + 6'h01;
	end else if (!row_n[2]) begin
		hit = 1'b1;
		hit_code = pos_cnt + 6'h02;
	end
end

assign frame_found = found | hit;
assign frame_code = found ? found_code : hit_code;
// Report only if the key was not already held during the previous frame
assign new_press = dwell_done && last_col && frame_found &&
	!(prev_found && (prev_code == frame_code));

always @(posedge aclk) begin
	if (!aresetn) begin
		state <= ST_OFF;
		col <= COL_ZERO;
		dwell_cnt <= {`KDS_CNT_W{1'b0}};
		pos_cnt <= {`KDS_CODE_W{1'b0}};
		found <= 1'b0;
		found_code <= {`KDS_CODE_W{1'b0}};
		prev_found <= 1'b0;
		prev_code <= {`KDS_CODE_W{1'b0}};
	end else begin
		case (state)
		ST_OFF: begin
			col <= COL_ZERO;
			dwell_cnt <= {`KDS_CNT_W{1'b0}};
			pos_cnt <= {`KDS_CODE_W{1'b0}};
			found <= 1'b0;
			prev_found <= 1'b0;
			if (scan_en) begin
				state <= ST_RUN;
			end
		end
		ST_RUN: begin
			if (!scan_en) begin
				state <= ST_OFF;
			end else if (dwell_done) begin
				dwell_cnt <= {`KDS_CNT_W{1'b0}};
				if (last_col) begin
					// Frame end: one examination per key every frame
					col <= COL_ZERO;
					pos_cnt <= {`KDS_CODE_W{1'b0}};
					found <= 1'b0;
					prev_found <= frame_found;
					prev_code <= frame_code;
				end else begin
					col <= col + 5'h01;
					if (!found) begin
						if (hit) begin
							found <= 1'b1;
							found_code <= hit_code;
						end else begin
							pos_cnt <= pos_cnt + CODE_STEP;
						end
					end
				end
			end else begin
				dwell_cnt <= dwell_cnt + 20'h00001;
			end
		end
		default: begin
			state <= ST_OFF;
		end
		endcase
	end
end

// ----------------------------------------------------------------
// Display outputs
// ----------------------------------------------------------------
reg [`KDS_DIGITS-1:0] next_digit_select_n;
reg [`KDS_SEGS-1:0] next_segment_n;
reg [`KDS_COL_W-1:0] next_col;

// Pattern and select are both derived from the column of the next cycle
always @* begin
	next_col = col;
	if (dwell_done) begin
		next_col = last_col ? COL_ZERO : col + 5'h01;
	end
	next_digit_select_n = {`KDS_DIGITS{1'b1}};
	next_segment_n = {`KDS_SEGS{1'b1}};
	if (state == ST_RUN && scan_en) begin
		next_digit_select_n[next_col] = 1'b0;
		next_segment_n = ~seg_mem[next_col];
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		digit_select_n <= {`KDS_DIGITS{1'b1}};
		segment_n <= {`KDS_SEGS{1'b1}};
	end else begin
		digit_select_n <= next_digit_select_n;
		segment_n <= next_segment_n;
	end
end

// ----------------------------------------------------------------
// AXI4-Lite write channel
// ----------------------------------------------------------------
reg aw_held;
reg w_held;
reg [`KDS_ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire do_write;
wire [`KDS_COL_W-1:0] w_idx;
wire w_seg;
wire [31:0] w_mask;
wire [31:0] w_merge;

assign do_write = aw_held && w_held && !s_axi_bvalid;
assign w_idx = aw_addr[`KDS_SEG_BASE_BIT-1:2];
assign w_seg = aw_addr[`KDS_SEG_BASE_BIT] && (w_idx <= `KDS_LAST_COL);
assign w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
	{8{w_strb[1]}}, {8{w_strb[0]}}};
assign w_merge = (w_data & w_mask) |
	({17'h00000, seg_mem[w_idx]} & ~w_mask);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `KDS_RESP_OKAY;
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= {`KDS_ADDR_W{1'b0}};
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		scan_en <= `KDS_CTRL_RST;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `KDS_RESP_OKAY;
			if (w_seg) begin
				seg_mem[w_idx] <= w_merge[`KDS_SEGS-1:0];
			end else if (aw_addr == `KDS_OFF_CTRL) begin
				if (w_strb[0]) begin
					scan_en <= w_data[`KDS_CTRL_EN];
				end
			end else if (aw_addr != `KDS_OFF_KEY &&
				aw_addr != `KDS_OFF_STAT) begin
				s_axi_bresp <= `KDS_RESP_SLVERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// AXI4-Lite read channel
// ----------------------------------------------------------------
wire rd_take;
wire [`KDS_COL_W-1:0] r_idx;
wire r_seg;
reg [31:0] next_rdata;
reg [1:0] next_rresp;

assign rd_take = s_axi_arvalid && s_axi_arready;
assign r_idx = s_axi_araddr[`KDS_SEG_BASE_BIT-1:2];
assign r_seg = s_axi_araddr[`KDS_SEG_BASE_BIT] &&
	(r_idx <= `KDS_LAST_COL);

always @* begin
	next_rdata = 32'h00000000;
	next_rresp = `KDS_RESP_OKAY;
	if (r_seg) begin
		next_rdata[`KDS_SEGS-1:0] = seg_mem[r_idx];
	end else if (s_axi_araddr == `KDS_OFF_CTRL) begin
		next_rdata[`KDS_CTRL_EN] = scan_en;
	end else if (s_axi_araddr == `KDS_OFF_KEY) begin
		next_rdata[`KDS_KEY_CODE_HI:0] = key_code;
		next_rdata[`KDS_KEY_SHIFT] = key_shift;
		next_rdata[`KDS_KEY_CTRL] = key_ctrl;
		next_rdata[`KDS_KEY_VALID] = key_valid;
	end else if (s_axi_araddr == `KDS_OFF_STAT) begin
		next_rdata[`KDS_STAT_COL_HI:0] = col;
		next_rdata[`KDS_STAT_RUN] = state;
		next_rdata[`KDS_STAT_PRESS] = prev_found;
	end else begin
		next_rresp = `KDS_RESP_SLVERR;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `KDS_RESP_OKAY;
	end else begin
		if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// Key report
// ----------------------------------------------------------------
wire key_read;

assign key_read = rd_take && (s_axi_araddr == `KDS_OFF_KEY);

// A new press in the reading cycle wins over the clear
always @(posedge aclk) begin
	if (!aresetn) begin
		key_valid <= 1'b0;
		key_code <= {`KDS_CODE_W{1'b0}};
		key_shift <= 1'b0;
		key_ctrl <= 1'b0;
	end else if (new_press) begin
		key_valid <= 1'b1;
		key_code <= frame_code;
		key_shift <= ~shift_n;
		key_ctrl <= ~ctrl_n;
	end else if (key_read) begin
		key_valid <= 1'b0;
	end
end

// Frame of 10 ms + 19 x 1 ms = 29 ms: 34 Hz refresh and key interval

endmodule // kds_scanner

//--- kds_scanner_props.sv
// Concurrent checks on the scanner pins and register bus
`timescale 1ns/1ns
`include "kds_scanner_regs.vh"
module kds_scanner_props #(
	parameter FIRST_DWELL_CYC = 40,
	parameter DWELL_CYC = 20
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [`KDS_DIGITS-1:0] digit_select_n,
	input wire [`KDS_SEGS-1:0] segment_n
);
	logic [`KDS_DIGITS-1:0] sel;
	logic [`KDS_DIGITS-1:0] prev_sel;
	logic [31:0] dwell;
	logic fresh;
	assign sel = ~digit_select_n;
	// ----
	// Dwell length of the selected digit; first one after a blank is partial
	// ----
	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_sel <= '0;
			dwell <= 32'h0;
			fresh <= 1'b1;
		end else begin
			prev_sel <= sel;
			dwell <= (sel == prev_sel) ? dwell + 32'h1 : 32'h1;
			if (sel != prev_sel)
				fresh <= (prev_sel == '0);
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence step;
		(sel != prev_sel) && (prev_sel != '0) && (sel != '0);
	endsequence
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	one_digit_a: assert property ($onehot0(sel))
		else $error("more than one digit selected");
	reset_quiet_a: assert property (disable iff (1'b0)
		!aresetn |=> &digit_select_n && &segment_n && !s_axi_bvalid
		&& !s_axi_rvalid) else $error("lines not idle in reset");
	scan_order_a: assert property (step |->
		sel == {prev_sel[18:0], prev_sel[19]})
		else $error("digit did not move one place left");
	dwell_len_a: assert property (step and !fresh |->
		dwell == (prev_sel[0] ? FIRST_DWELL_CYC : DWELL_CYC))
		else $error("digit dwell length wrong");
	seg_with_digit_a: assert property ($changed(segment_n) |->
		$changed(digit_select_n)) else $error("segments moved alone");
	b_follows_a: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	r_follows_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
endmodule // kds_scanner_props

bind kds_scanner kds_scanner_props #(
	.FIRST_DWELL_CYC(FIRST_DWELL_CYC),
	.DWELL_CYC(DWELL_CYC)
) i_kds_scanner_props (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.digit_select_n(digit_select_n), .segment_n(segment_n)
);

//--- kds_panel_model.sv
// Display panel and passive key matrix seen from the scanner pins
`timescale 1ns/1ns
`include "kds_scanner_regs.vh"
module kds_panel_model (
	input wire aclk,
	input wire [`KDS_DIGITS-1:0] digit_select_n,
	input wire [`KDS_SEGS-1:0] segment_n,
	input wire key_down,
	input wire [5:0] key_code,
	input wire [4:0] watch_digit,
	output logic [`KDS_ROWS-1:0] key_row_n,
	output logic [`KDS_SEGS-1:0] watch_lit
);
	logic [`KDS_SEGS-1:0] lit_mem [0:`KDS_DIGITS-1];
	int i;
	// Rows float to the pull-up unless the closed node's column is low
	always_comb begin
		key_row_n = 3'h7;
		if (key_down && !digit_select_n[key_code / 3])
			key_row_n[key_code % 3] = 1'b0;
	end
	// A digit keeps the segments it last lit while it was selected
	always @(posedge aclk) begin
		for (i = 0; i < `KDS_DIGITS; i++)
			if (!digit_select_n[i])
				lit_mem[i] <= ~segment_n;
	end
	assign watch_lit = lit_mem[watch_digit];
endmodule // kds_panel_model

//--- kds_scanner_tb.sv
// Register-level testbench of the key and display scanner
`timescale 1ns/1ns
`include "kds_scanner_regs.vh"
module kds_scanner_tb;
	localparam int FIRST = 40;
	localparam int DWELL = 20;
	localparam int FRAME = FIRST + 19 * DWELL;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, key_down;
	logic shift_key_input_n, control_key_input_n;
	logic [`KDS_DIGITS-1:0] digit_select_n;
	logic [`KDS_SEGS-1:0] segment_n, watch_lit;
	logic [`KDS_ROWS-1:0] key_row_n;
	logic [5:0] key_code;
	logic [4:0] watch_digit;
	int bad_count, tests_run, i;
	logic [4:0] seg_dig [4] = '{5'h00, 5'h01, 5'h08, 5'h13};
	logic [14:0] seg_pat [4] = '{15'h0001, 15'h0000, 15'h0100, 15'h4000};
	logic [5:0] k_code [3] = '{6'h00, 6'h11, 6'h3b};
	logic [1:0] k_mod [3] = '{2'h0, 2'h1, 2'h2};

	kds_scanner #(.FIRST_DWELL_CYC(FIRST), .DWELL_CYC(DWELL)) i_kds_scanner (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.digit_select_n(digit_select_n), .segment_n(segment_n),
		.key_row_n(key_row_n), .shift_key_input_n(shift_key_input_n),
		.control_key_input_n(control_key_input_n)
	);
	kds_panel_model i_kds_panel_model (
		.aclk(aclk), .digit_select_n(digit_select_n), .segment_n(segment_n),
		.key_down(key_down), .key_code(key_code), .watch_digit(watch_digit),
		.key_row_n(key_row_n), .watch_lit(watch_lit)
	);

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// ----
	// Checking and reporting
	// ----
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] got, input logic [31:0] mask);
		tests_run++;
		if (((got ^ exp) & mask) !== 32'h0) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp & mask, got & mask);
		end
	endtask
	task automatic chk_resp(input string what, input logic [1:0] exp,
		input logic [1:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hang();
		bad_count++;
		$display("Error bus answer expected seen none");
		give_verdict();
	endtask

	// ----
	// Bus master tasks
	// ----
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bready <= 1'b0;
				chk_resp("bresp", er, s_axi_bresp);
				return;
			end
			if (s_axi_bvalid)
				s_axi_bready <= 1'b1;
		end
		hang();
	endtask
	task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] mask, input logic [1:0] er, input string what);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rready <= 1'b0;
				chk_word(what, exp, s_axi_rdata, mask);
				chk_resp("rresp", er, s_axi_rresp);
				return;
			end
			if (s_axi_rvalid)
				s_axi_rready <= 1'b1;
		end
		hang();
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		bad_count = 0;
		tests_run = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, key_down} = 3'h0;
		{shift_key_input_n, control_key_input_n} = 2'h3;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		key_code = 6'h0;
		watch_digit = 5'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axi_write(`KDS_OFF_KEY, 32'hffffffff, `KDS_RESP_OKAY);
		axi_read(`KDS_OFF_KEY, 0, 32'h80000000, 0, "idle key");
		axi_read(`KDS_OFF_STAT, 32'h100, 32'h100, 0, "running");
		axi_write(8'h40, 32'h1, `KDS_RESP_SLVERR);
		axi_read(8'h40, 0, 32'hffffffff, `KDS_RESP_SLVERR, "unmapped");
		axi_write(`KDS_OFF_CTRL, 32'h0, `KDS_RESP_OKAY);
		for (i = 0; i < 4; i++)
			axi_write({1'b1, seg_dig[i], 2'b00}, 32'(seg_pat[i]), 0);
		axi_write(`KDS_OFF_CTRL, 32'h1, `KDS_RESP_OKAY);
		repeat (2 * FRAME) @(posedge aclk);
		for (i = 0; i < 4; i++) begin
			watch_digit <= seg_dig[i];
			@(posedge aclk);
			chk_word("lit", 32'(seg_pat[i]), 32'(watch_lit), 32'h7fff);
		end
		for (i = 0; i < 3; i++) begin
			@(posedge aclk);
			key_code <= k_code[i];
			shift_key_input_n <= ~k_mod[i][0];
			control_key_input_n <= ~k_mod[i][1];
			key_down <= 1'b1;
			repeat (2 * FRAME + 20) @(posedge aclk);
			axi_read(`KDS_OFF_KEY, {1'b1, 21'h0, k_mod[i], 2'b00, k_code[i]},
				32'h8000033f, 0, "new key");
			axi_read(`KDS_OFF_KEY, 0, 32'h80000000, 0, "read clear");
			repeat (FRAME + 20) @(posedge aclk);
			axi_read(`KDS_OFF_KEY, 0, 32'h80000000, 0, "held key");
			axi_read(`KDS_OFF_STAT, 32'h300, 32'h300, 0, "held stat");
			key_down <= 1'b0;
			repeat (2 * FRAME) @(posedge aclk);
		end
		give_verdict();
	end
endmodule // kds_scanner_tb
